// ==== core/mclr_pkg.sv ====
// Package for the motor control loop event router: constants and carriers
package mclr_pkg;

   // Fetch windows after a reload, in bus cycles
   localparam int unsigned SCHED_FETCH_CYCLES = 7;
   localparam int unsigned ADC_FETCH_CYCLES   = 10;
   localparam logic [3:0]  SCHED_FETCH_LAST   = 4'(SCHED_FETCH_CYCLES);
   localparam logic [3:0]  ADC_FETCH_LAST     = 4'(ADC_FETCH_CYCLES);
   localparam logic [3:0]  WINDOW_RESET       = 4'h0;

   // Reload divider: reload once every N PWM periods
   localparam int unsigned RELOAD_DIV_W   = 4;
   localparam logic [3:0]  PERIOD_CNT_RST = 4'h0;

   // Trigger time base and list
   localparam int unsigned TIME_W        = 16;
   localparam int unsigned LIST_DEPTH    = 4;
   localparam int unsigned LIST_IDX_W    = 2;
   localparam logic [15:0] TIME_BASE_RST = 16'h0000;
   localparam logic [1:0]  LIST_IDX_RST  = 2'h0;

   // Events presented to each converter
   typedef struct packed {
      logic restart;
      logic seq_abort;
      logic trigger;
      logic commit;
   } mclr_adc_evt_t;

   // Events presented to the gate driver
   typedef struct packed {
      logic reload;
      logic async_reload;
   } mclr_gate_evt_t;

   // Scheduler fetch progress states
   typedef enum logic [1:0] {
      MCLR_IDLE,
      MCLR_FETCH,
      MCLR_RUN
   } mclr_sched_state_t;

endpackage

// ==== core/mclr_router.sv ====
// Motor control loop event router: timer, modulator, scheduler, two converters
`timescale 1ns/1ps
module mclr_router (
   input  wire logic                                  ref_clk,
   input  wire logic                                  rst_n,
   input  wire logic                                  clk_en,
   input  wire logic                                  pwm_period_end,
   input  wire logic [mclr_pkg::RELOAD_DIV_W-1:0]     reload_every,
   input  wire logic                                  compare_channel_zero,
   input  wire logic                                  scheduler_enable,
   input  wire logic                                  scheduler_commit_bit,
   input  wire logic                                  simultaneous,
   input  wire logic                                  list_we,
   input  wire logic [mclr_pkg::LIST_IDX_W-1:0]       list_waddr,
   input  wire logic [mclr_pkg::TIME_W-1:0]           list_wtime,
   input  wire logic                                  list_wsel,
   input  wire logic [mclr_pkg::LIST_IDX_W-1:0]       list_count,
   output mclr_pkg::mclr_adc_evt_t                    adc0_evt,
   output mclr_pkg::mclr_adc_evt_t                    adc1_evt,
   output mclr_pkg::mclr_gate_evt_t                   gate_driver_evt,
   output logic                                       adc0_convert,
   output logic                                       adc1_convert,
   output logic                                       adc0_fetching,
   output logic                                       adc1_fetching,
   output logic                                       sched_fetching,
   output logic [mclr_pkg::TIME_W-1:0]                time_base
);
   import mclr_pkg::*;

   logic [RELOAD_DIV_W-1:0] period_cnt;
   logic                    reload;
   logic                    async_reload;
   logic                    comm_q;
   logic                    loop_restart;
   logic [3:0]              sched_win;
   logic [3:0]              adc_win;
   logic [TIME_W-1:0]       list_time [LIST_DEPTH];
   logic                    list_sel  [LIST_DEPTH];
   logic [LIST_IDX_W-1:0]   list_idx;
   logic                    list_done;
   logic                    hit;
   logic                    trig0;
   logic                    trig1;
   logic                    adc0_armed;
   logic                    adc1_armed;
   mclr_sched_state_t       sched_state;

   // Reload every reload_every+1 periods; zero means every period
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         period_cnt <= PERIOD_CNT_RST;
         reload     <= 1'b0;
      end else if (clk_en) begin
         reload <= 1'b0;
         if (pwm_period_end) begin
            if (period_cnt >= reload_every) begin
               period_cnt <= PERIOD_CNT_RST;
               reload     <= 1'b1;
            end else begin
               period_cnt <= period_cnt + 4'h1;
            end
         end
      end
   end

   // Compare channel is on-chip logic on the same clock: edge gives commutation
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         comm_q       <= 1'b0;
         async_reload <= 1'b0;
      end else if (clk_en) begin
         comm_q       <= compare_channel_zero;
         // Channel toggles on each event, so both edges count
         async_reload <= compare_channel_zero ^ comm_q;
      end
   end

   assign loop_restart = reload | async_reload;

   // Trigger list storage, written by the owning software side
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < LIST_DEPTH; i++) begin
            list_time[i] <= TIME_BASE_RST;
            list_sel[i]  <= 1'b0;
         end
      end else if (clk_en && list_we) begin
         list_time[list_waddr] <= list_wtime;
         list_sel[list_waddr]  <= list_wsel;
      end
   end

   // Time base restarts on every reload
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         time_base <= TIME_BASE_RST;
      end else if (clk_en) begin
         if (loop_restart) begin
            time_base <= TIME_BASE_RST;
         end else if (scheduler_enable) begin
            time_base <= time_base + 16'h0001;
         end
      end
   end

   // Scheduler fetch window and list walk
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sched_state <= MCLR_IDLE;
         sched_win   <= WINDOW_RESET;
         list_idx    <= LIST_IDX_RST;
         list_done   <= 1'b0;
      end else if (clk_en) begin
         if (!scheduler_enable) begin
            sched_state <= MCLR_IDLE;
         end else if (loop_restart) begin
            // Async reload reloads the list the same way a reload does
            sched_state <= MCLR_FETCH;
            sched_win   <= WINDOW_RESET;
            list_idx    <= LIST_IDX_RST;
            list_done   <= 1'b0;
         end else begin
            unique case (sched_state)
               MCLR_IDLE: sched_state <= MCLR_IDLE;
               MCLR_FETCH: begin
                  sched_win <= sched_win + 4'h1;
                  if (sched_win + 4'h1 >= SCHED_FETCH_LAST) begin
                     sched_state <= MCLR_RUN;
                  end
               end
               MCLR_RUN: begin
                  if (hit) begin
                     if (list_idx == list_count) begin
                        list_done <= 1'b1;
                     end else begin
                        list_idx <= list_idx + 2'h1;
                     end
                  end
               end
            endcase
         end
      end
   end

   assign sched_fetching = (sched_state == MCLR_FETCH);
   assign hit = scheduler_enable && (sched_state == MCLR_RUN) && !list_done
                && !loop_restart && (time_base == list_time[list_idx]);

   // Trigger pulses; simultaneous mode fires both converters together
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         trig0 <= 1'b0;
         trig1 <= 1'b0;
      end else if (clk_en) begin
         trig0 <= hit && (simultaneous || !list_sel[list_idx]);
         trig1 <= hit && (simultaneous ||  list_sel[list_idx]);
      end
   end

   // Converter command fetch window, shared by both converters
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         adc_win <= WINDOW_RESET;
      end else if (clk_en) begin
         if (reload && scheduler_enable) begin
            adc_win <= ADC_FETCH_LAST;
         end else if (adc_win != WINDOW_RESET) begin
            adc_win <= adc_win - 4'h1;
         end
      end
   end

   assign adc0_fetching = (adc_win != WINDOW_RESET);
   assign adc1_fetching = (adc_win != WINDOW_RESET);

   // A converter is armed once its command fetch window runs out
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         adc0_armed   <= 1'b0;
         adc1_armed   <= 1'b0;
         adc0_convert <= 1'b0;
         adc1_convert <= 1'b0;
      end else if (clk_en) begin
         // A trigger that meets a restart or an abort belongs to the old sequence
         adc0_convert <= trig0 && adc0_armed && !adc0_fetching
                         && !adc0_evt.restart && !adc0_evt.seq_abort;
         adc1_convert <= trig1 && adc1_armed && !adc1_fetching
                         && !adc1_evt.restart && !adc1_evt.seq_abort;
         if (async_reload && scheduler_enable) begin
            adc0_armed <= 1'b0;
            adc1_armed <= 1'b0;
         end else if (adc_win == 4'h1) begin
            adc0_armed <= 1'b1;
            adc1_armed <= 1'b1;
         end
      end
   end

   // Pass-through is combinational: no queuing between modulator and sinks
   always_comb begin
      adc0_evt.restart   = reload & scheduler_enable;
      adc0_evt.seq_abort = async_reload & scheduler_enable;
      adc0_evt.trigger   = trig0;
      adc0_evt.commit    = scheduler_commit_bit;
      adc1_evt.restart   = reload & scheduler_enable;
      adc1_evt.seq_abort = async_reload & scheduler_enable;
      adc1_evt.trigger   = trig1;
      adc1_evt.commit    = scheduler_commit_bit;
      gate_driver_evt.reload       = reload & scheduler_enable;
      gate_driver_evt.async_reload = async_reload & scheduler_enable;
   end

   chk_reload_pass: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reload && scheduler_enable |-> adc0_evt.restart && adc1_evt.restart
         && gate_driver_evt.reload)
      else $error("reload not forwarded");

   chk_block_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !scheduler_enable |-> !adc0_evt.restart && !adc1_evt.seq_abort
         && !gate_driver_evt.async_reload)
      else $error("event forwarded while disabled");

   chk_sched_window: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && loop_restart && scheduler_enable |=> !trig0 && !trig1)
      else $error("trigger inside fetch window");

   sequence s_reload_en;
      reload && scheduler_enable && clk_en;
   endsequence

   chk_adc_window: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_reload_en |=> !adc0_convert [*8])
      else $error("conversion inside command window");

   chk_pulse_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && reload |=> !reload)
      else $error("reload longer than a cycle");

   chk_comm_async: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && (compare_channel_zero != comm_q) |=> async_reload)
      else $error("commutation not answered");

   chk_time_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && loop_restart |=> time_base == TIME_BASE_RST)
      else $error("time base not restarted");

   chk_simul_trig: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && hit && simultaneous |=> trig0 && trig1)
      else $error("simultaneous triggers split");

   chk_abort_fwd: assert property (@(posedge ref_clk) disable iff (!rst_n)
      async_reload && scheduler_enable |-> adc0_evt.seq_abort && adc1_evt.seq_abort)
      else $error("abort not forwarded");

   chk_list_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && async_reload && scheduler_enable |=> sched_fetching
         && list_idx == LIST_IDX_RST)
      else $error("list not reinitialised");

   chk_fetch_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sched_fetching |-> !trig0 && !trig1)
      else $error("trigger while fetching list");

   chk_off_trig: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && !scheduler_enable |=> !trig0 && !trig1)
      else $error("trigger while disabled");

   sequence s_trig0_ready;
      clk_en && trig0 && adc0_armed && !adc0_fetching && !adc0_evt.restart && !adc0_evt.seq_abort;
   endsequence

   sequence s_trig1_ready;
      clk_en && trig1 && adc1_armed && !adc1_fetching && !adc1_evt.restart && !adc1_evt.seq_abort;
   endsequence

   chk_start_conv0: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_trig0_ready |=> adc0_convert)
      else $error("converter zero not started");

   chk_start_conv1: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_trig1_ready |=> adc1_convert)
      else $error("converter one not started");

   chk_div_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && pwm_period_end && period_cnt < reload_every |=> !reload)
      else $error("reload before period count");

   chk_gate_async: assert property (@(posedge ref_clk) disable iff (!rst_n)
      async_reload && scheduler_enable |-> gate_driver_evt.async_reload)
      else $error("async reload not forwarded");

endmodule // mclr_router

// ==== verification/mclr_source_model.sv ====
// Far-side model: modulator period source, compare channel and commit bit
`timescale 1ns/1ps
module mclr_source_model (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [7:0] period_len,
   input  wire logic       commute_req,
   output logic            pwm_period_end,
   output logic            compare_channel_zero,
   output logic            scheduler_commit_bit
);
   logic [7:0] count;
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !run) begin
         count <= 8'h00;
         pwm_period_end <= 1'b0;
      end else begin
         pwm_period_end <= (count == period_len - 8'h01);
         count <= (count == period_len - 8'h01) ? 8'h00 : count + 8'h01;
      end
   end
   // Each toggle is one commutation, so both edges are used
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         compare_channel_zero <= 1'b0;
      end else if (commute_req) begin
         compare_channel_zero <= ~compare_channel_zero;
      end
   end
   // Settings are written before the loop starts, so commit stands ahead of every reload
   always_ff @(posedge ref_clk) begin
      scheduler_commit_bit <= rst_n & run;
   end
endmodule // mclr_source_model

// ==== verification/motor_control_loop_event_routing_test.sv ====
// Self-checking bench for the motor control loop event router
`timescale 1ns/1ps
module motor_control_loop_event_routing_test;
   import mclr_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic run = 1'b0;
   logic commute_req = 1'b0;
   logic [7:0] period_len = 8'h3C;
   logic [3:0] reload_every = 4'h0;
   logic scheduler_enable = 1'b1;
   logic simultaneous = 1'b0;
   logic list_we = 1'b0;
   logic [1:0] list_waddr = 2'h0;
   logic [15:0] list_wtime = 16'h0000;
   logic list_wsel = 1'b0;
   logic [1:0] list_count = 2'h3;
   logic pwm_period_end, compare_channel_zero, scheduler_commit_bit;
   mclr_adc_evt_t adc0_evt, adc1_evt;
   mclr_gate_evt_t gate_driver_evt;
   logic adc0_convert, adc1_convert, adc0_fetching, adc1_fetching, sched_fetching;
   logic [15:0] time_base;
   int failures = 0;
   int n_tests = 0;
   always #12.5 ref_clk = ~ref_clk;
   mclr_source_model model (.ref_clk, .rst_n, .run, .period_len, .commute_req,
      .pwm_period_end, .compare_channel_zero, .scheduler_commit_bit);
   mclr_router dut (.ref_clk, .rst_n, .clk_en, .pwm_period_end, .reload_every,
      .compare_channel_zero, .scheduler_enable, .scheduler_commit_bit, .simultaneous,
      .list_we, .list_waddr, .list_wtime, .list_wsel, .list_count, .adc0_evt, .adc1_evt,
      .gate_driver_evt, .adc0_convert, .adc1_convert, .adc0_fetching, .adc1_fetching,
      .sched_fetching, .time_base);
   task automatic results;
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step;
      @(posedge ref_clk);
      #1;
   endtask
   function automatic logic pick(input int k);
      return (k == 0) ? pwm_period_end : gate_driver_evt.async_reload;
   endfunction
   // Bounded wait; a hang ends the run with a failure
   task automatic wait_for(input int k);
      for (int i = 0; i < 300 && pick(k) !== 1'b1; i++) step();
      if (pick(k) !== 1'b1) begin
         check(0, 1);
         results();
      end
   endtask
   task automatic put(input logic sel, input logic [1:0] a, input logic [15:0] t);
      list_we = 1'b1;
      list_wsel = sel;
      list_waddr = a;
      list_wtime = t;
      step();
      list_we = 1'b0;
      step();
   endtask
   task automatic t_forward;
      int s, a, b;
      s = 0;
      a = 0;
      b = 0;
      wait_for(0);
      step();
      check({adc0_evt.restart, adc1_evt.restart, gate_driver_evt}, 4'hE);
      check({adc0_evt.commit, adc1_evt.commit}, 2'h3);
      step();
      check({adc0_evt.restart, gate_driver_evt.reload, time_base}, 0);
      for (int i = 0; i < 15; i++) begin
         s += int'(sched_fetching);
         a += int'(adc0_fetching);
         b += int'(adc1_fetching);
         step();
      end
      check(s, SCHED_FETCH_CYCLES);
      check(a + b, 2 * ADC_FETCH_CYCLES);
   endtask
   // Counts triggers and the converts that follow them over one control cycle
   task automatic t_list(input logic sim);
      int t0, t1, v0, v1, p0, p1, both, diff;
      logic [15:0] at0, at1;
      t0 = 0;
      t1 = 0;
      v0 = 0;
      v1 = 0;
      p0 = 0;
      p1 = 0;
      both = 0;
      diff = 0;
      simultaneous = sim;
      wait_for(0);
      for (int i = 0; i < 58; i++) begin
         step();
         v0 += int'(adc0_convert) & p0;
         v1 += int'(adc1_convert) & p1;
         p0 = int'(adc0_evt.trigger);
         p1 = int'(adc1_evt.trigger);
         t0 += p0;
         t1 += p1;
         both += p0 & p1;
         diff += int'(adc0_evt.trigger !== adc1_evt.trigger);
         if (p0 == 1 && t0 == 1) at0 = time_base;
         if (p1 == 1 && t1 == 1) at1 = time_base;
      end
      if (sim) begin
         check(diff, 0);
         check(t0, 4);
         check(both, 4);
         check(v0 + v1, 8);
      end else begin
         check(t0, 2);
         check(t1, 2);
         check(v0, 2);
         check(v1, 2);
         check(32'(at1 - at0), 10);
         check(both, 0);
      end
      simultaneous = 1'b0;
   endtask
   task automatic t_div;
      int e, r;
      e = 0;
      r = 0;
      reload_every = 4'h2;
      wait_for(0);
      step();
      for (int i = 0; i < 180; i++) begin
         step();
         e += int'(pwm_period_end);
         r += int'(adc0_evt.restart);
      end
      check(e, 3);
      check(r, 1);
      reload_every = 4'h0;
   endtask
   task automatic t_off;
      int c;
      c = 0;
      scheduler_enable = 1'b0;
      wait_for(0);
      commute_req = 1'b1;
      for (int i = 0; i < 62; i++) begin
         step();
         commute_req = 1'b0;
         c += int'(|{adc0_evt[3:1], adc1_evt[3:1], gate_driver_evt, adc0_convert, adc1_convert});
      end
      check(c, 0);
      scheduler_enable = 1'b1;
   endtask
   task automatic t_async;
      int c, t;
      logic [15:0] snap;
      c = 0;
      t = 0;
      wait_for(0);
      repeat (20) step();
      for (int k = 0; k < 2; k++) begin
         commute_req = 1'b1;
         step();
         commute_req = 1'b0;
         wait_for(1);
         check({adc0_evt.seq_abort, adc1_evt.seq_abort, gate_driver_evt}, 4'hD);
         step();
      end
      for (int i = 0; i < 100 && pwm_period_end !== 1'b1; i++) begin
         c += int'(adc0_convert | adc1_convert);
         t += int'(adc0_evt.trigger) + int'(adc1_evt.trigger);
         step();
      end
      check(c, 0);
      check(t, 2);
      // Frozen clock enable must hold the time base still
      snap = time_base;
      clk_en = 1'b0;
      repeat (5) step();
      check(time_base, snap);
      clk_en = 1'b1;
   endtask
   initial begin
      repeat (8) step();
      rst_n = 1'b1;
      check({adc0_evt[3:1], adc1_evt[3:1], gate_driver_evt, time_base}, 0);
      // One list in time order; the select bit picks the converter
      put(1'b0, 2'h0, 16'h0014);
      put(1'b1, 2'h1, 16'h001E);
      put(1'b0, 2'h2, 16'h0028);
      put(1'b1, 2'h3, 16'h0032);
      run = 1'b1;
      t_forward();
      t_list(1'b0);
      t_list(1'b1);
      t_div();
      t_off();
      t_async();
      results();
   end
endmodule // motor_control_loop_event_routing_test
